// ===== dv/tb_tma_access.sv
// self-checking bench for the timer byte windows, read latching and flags
// assumes tma_pkg is compiled first; the bench drives every input port of the block
module tb_tma_access;
  timeunit 1ns;
  timeprecision 100ps;

  // ***********************************************
  // stimulus and observed signals
  // ***********************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_rd = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [15:0] upcount_value = 16'h0001;
  logic [15:0] upcount_capture = 16'hC0DE;
  logic [23:0] wrap_count_value = 24'h00_0000;
  logic [23:0] wrap_count_capture = 24'h9A_8765;
  logic period_wrap_evt = 1'b0;
  logic wrap_period_evt = 1'b0;
  logic upcount_load;
  logic wrap_load;
  logic latch_mode;
  logic timer_irq;
  logic [15:0] upcount_load_value;
  logic [15:0] upcount_period;
  logic [15:0] upcount_compare_a;
  logic [15:0] upcount_compare_b;
  logic [23:0] wrap_load_value;
  logic [23:0] wrap_count_period;
  logic [23:0] wrap_count_compare_a;
  logic [23:0] wrap_count_compare_b;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [2:0] sel;
  logic [7:0] hb;
  logic [7:0] mb;
  logic [7:0] lb;
  logic [15:0] got_t;
  logic [23:0] got_o;
  logic [7:0] zero_regs [7] = '{8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'h00};

  tma_access #(.EXTENDED(1'b1)) dut (
    .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .upcount_value(upcount_value), .upcount_capture(upcount_capture),
    .wrap_count_value(wrap_count_value), .wrap_count_capture(wrap_count_capture),
    .period_wrap_evt(period_wrap_evt), .wrap_period_evt(wrap_period_evt),
    .upcount_load(upcount_load), .upcount_load_value(upcount_load_value),
    .wrap_load(wrap_load), .wrap_load_value(wrap_load_value),
    .upcount_period(upcount_period), .upcount_compare_a(upcount_compare_a),
    .upcount_compare_b(upcount_compare_b), .wrap_count_period(wrap_count_period),
    .wrap_count_compare_a(wrap_count_compare_a),
    .wrap_count_compare_b(wrap_count_compare_b),
    .latch_mode(latch_mode), .timer_irq(timer_irq)
  );

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // hang guard, ceiling well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  // ***********************************************
  // access tasks and comparisons
  // ***********************************************
  // waits n edges, then lets that edge's updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // read data is registered at the strobe edge, so it is taken just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
    v = sfr_rdata;
  endtask

  task automatic pulse(input bit on_wrap);
    @(posedge clock);
    if (on_wrap) wrap_period_evt <= 1'b1;
    else period_wrap_evt <= 1'b1;
    @(posedge clock);
    period_wrap_evt <= 1'b0;
    wrap_period_evt <= 1'b0;
    #1;
  endtask

  task automatic setv(input logic [15:0] u, input logic [23:0] w);
    @(posedge clock);
    upcount_value <= u;
    wrap_count_value <= w;
    tick(2);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ***********************************************
  // test sequence
  // ***********************************************
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    tick(1);
    // reset values, unmapped address last
    foreach (zero_regs[k]) begin
      rd(zero_regs[k], d);
      chk_byte(d, 8'h00);
    end
    chk_port({8'h00, upcount_period}, 24'h00_0000);
    // reserved select bits read zero
    wr(tma_pkg::ADDR_SELECT, 8'hFF);
    rd(tma_pkg::ADDR_SELECT, d);
    chk_byte(d, 8'h77);
    // capture targets are read-only
    wr(tma_pkg::ADDR_SELECT, 8'h11);
    wr(tma_pkg::ADDR_TIM_HI, 8'hFF);
    rd(tma_pkg::ADDR_TIM_HI, d);
    chk_byte(d, 8'hC0);
    rd(tma_pkg::ADDR_OVF_TOP, d);
    chk_byte(d, 8'h9A);
    wr(tma_pkg::ADDR_SELECT, 8'h55);
    rd(tma_pkg::ADDR_TIM_HI, d);
    chk_byte(d, 8'h00);
    rd(tma_pkg::ADDR_OVF_MID, d);
    chk_byte(d, 8'h00);
    // period and compare targets through every window
    for (int i = 2; i <= 4; i++) begin
      sel = 3'(i);
      hb = 8'hA0 | 8'(i);
      mb = 8'h40 | 8'(i);
      lb = 8'h50 | 8'(i);
      wr(tma_pkg::ADDR_SELECT, {1'b0, sel, 1'b0, sel});
      wr(tma_pkg::ADDR_TIM_HI, hb);
      wr(tma_pkg::ADDR_TIM_LO, lb);
      wr(tma_pkg::ADDR_OVF_LO, lb);
      wr(tma_pkg::ADDR_OVF_MID, mb);
      wr(tma_pkg::ADDR_OVF_TOP, hb);
      rd(tma_pkg::ADDR_TIM_HI, d);
      chk_byte(d, hb);
      rd(tma_pkg::ADDR_OVF_LO, d);
      chk_byte(d, lb);
      case (sel)
        3'b010: begin
          got_t = upcount_period;
          got_o = wrap_count_period;
        end
        3'b011: begin
          got_t = upcount_compare_a;
          got_o = wrap_count_compare_a;
        end
        default: begin
          got_t = upcount_compare_b;
          got_o = wrap_count_compare_b;
        end
      endcase
      chk_port({8'h00, got_t}, {8'h00, hb, lb});
      chk_port(got_o, {hb, mb, lb});
    end
    // latch mode 0: low windows latch their own counter
    wr(tma_pkg::ADDR_SELECT, 8'h00);
    setv(16'h1234, 24'h12_3456);
    rd(tma_pkg::ADDR_TIM_LO, d);
    chk_byte(d, 8'h34);
    rd(tma_pkg::ADDR_OVF_LO, d);
    chk_byte(d, 8'h56);
    setv(16'hABCD, 24'hA1_B2C3);
    rd(tma_pkg::ADDR_TIM_HI, d);
    chk_byte(d, 8'h12);
    rd(tma_pkg::ADDR_OVF_MID, d);
    chk_byte(d, 8'h34);
    rd(tma_pkg::ADDR_OVF_TOP, d);
    chk_byte(d, 8'h12);
    // latch mode 1: timer low read latches both counters
    wr(tma_pkg::ADDR_CONTROL, 8'hFF);
    chk_port(24'(latch_mode), 24'h00_0001);
    rd(tma_pkg::ADDR_CONTROL, d);
    chk_byte(d, 8'h08);
    rd(tma_pkg::ADDR_TIM_LO, d);
    chk_byte(d, 8'hCD);
    setv(16'h1111, 24'h44_5566);
    rd(tma_pkg::ADDR_OVF_LO, d);
    chk_byte(d, 8'hC3);
    rd(tma_pkg::ADDR_OVF_MID, d);
    chk_byte(d, 8'hB2);
    rd(tma_pkg::ADDR_OVF_TOP, d);
    chk_byte(d, 8'hA1);
    rd(tma_pkg::ADDR_TIM_HI, d);
    chk_byte(d, 8'hAB);
    // low then high read with one quiet cycle between
    rd(tma_pkg::ADDR_TIM_LO, d);
    chk_byte(d, 8'h11);
    rd(tma_pkg::ADDR_TIM_HI, d);
    chk_byte(d, 8'h11);
    // count writes become load pulses
    wr(tma_pkg::ADDR_TIM_HI, 8'h77);
    chk_port({8'h00, upcount_load, 15'h0000}, 24'h00_8000);
    chk_port({8'h00, upcount_load_value}, 24'h00_7711);
    tick(1);
    chk_port(24'(upcount_load), 24'h00_0000);
    wr(tma_pkg::ADDR_OVF_MID, 8'h99);
    chk_port(24'(wrap_load), 24'h00_0001);
    chk_port(wrap_load_value, 24'h44_9966);
    // compares for the flag tests
    wr(tma_pkg::ADDR_SELECT, 8'h33);
    wr(tma_pkg::ADDR_TIM_HI, 8'h00);
    wr(tma_pkg::ADDR_TIM_LO, 8'h10);
    wr(tma_pkg::ADDR_OVF_MID, 8'h00);
    wr(tma_pkg::ADDR_OVF_TOP, 8'h00);
    wr(tma_pkg::ADDR_OVF_LO, 8'h05);
    wr(tma_pkg::ADDR_SELECT, 8'h44);
    wr(tma_pkg::ADDR_TIM_HI, 8'h00);
    wr(tma_pkg::ADDR_TIM_LO, 8'h20);
    wr(tma_pkg::ADDR_OVF_MID, 8'h00);
    wr(tma_pkg::ADDR_OVF_TOP, 8'h00);
    wr(tma_pkg::ADDR_OVF_LO, 8'h06);
    setv(16'h0001, 24'h00_0001);
    wr(tma_pkg::ADDR_FLAGS, 8'h00);
    // period flag, masking and write-zero clear
    pulse(1'b0);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h01);
    chk_port(24'(timer_irq), 24'h00_0000);
    wr(tma_pkg::ADDR_MASK, 8'h01);
    tick(1);
    chk_port(24'(timer_irq), 24'h00_0001);
    wr(tma_pkg::ADDR_FLAGS, 8'hFF);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h01);
    wr(tma_pkg::ADDR_FLAGS, 8'h00);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h00);
    chk_port(24'(timer_irq), 24'h00_0000);
    // compare and wrap events
    setv(16'h0010, 24'h00_0001);
    setv(16'h0020, 24'h00_0001);
    setv(16'h0020, 24'h00_0005);
    setv(16'h0020, 24'h00_0006);
    pulse(1'b1);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h3E);
    // joint compares
    wr(tma_pkg::ADDR_FLAGS, 8'h00);
    setv(16'h0010, 24'h00_0005);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h52);
    setv(16'h0020, 24'h00_0006);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'hF6);
    wr(tma_pkg::ADDR_MASK, 8'hFF);
    rd(tma_pkg::ADDR_MASK, d);
    chk_byte(d, 8'hFF);
    wr(tma_pkg::ADDR_MASK, 8'h80);
    tick(1);
    chk_port(24'(timer_irq), 24'h00_0001);
    // event in the same cycle as a clearing write
    @(posedge clock);
    sfr_addr <= tma_pkg::ADDR_FLAGS;
    sfr_wdata <= 8'h00;
    sfr_wr <= 1'b1;
    period_wrap_evt <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
    period_wrap_evt <= 1'b0;
    tick(1);
    rd(tma_pkg::ADDR_FLAGS, d);
    chk_byte(d, 8'h01);
    chk_port(24'(timer_irq), 24'h00_0000);
    conclude();
  end
endmodule

// ===== inc/tma_pkg.sv
// constants for the multiplexed timer access and interrupt flag block
// assumes a byte-wide register port and one system clock
package tma_pkg;

  // ***********************************************
  // register offsets on the byte port
  // ***********************************************
  localparam logic [7:0] ADDR_FLAGS = 8'hA1;
  localparam logic [7:0] ADDR_TIM_LO = 8'hA2;
  localparam logic [7:0] ADDR_TIM_HI = 8'hA3;
  localparam logic [7:0] ADDR_OVF_LO = 8'hA4;
  localparam logic [7:0] ADDR_OVF_MID = 8'hA5;
  localparam logic [7:0] ADDR_OVF_TOP = 8'hA6;
  localparam logic [7:0] ADDR_MASK = 8'hA7;
  localparam logic [7:0] ADDR_SELECT = 8'hC3;
  localparam logic [7:0] ADDR_CONTROL = 8'h94;

  // ***********************************************
  // field layout and widths
  // ***********************************************
  localparam int BYTE_W = 8;
  localparam int TIM_W = 16;
  localparam int OVF_W = 24;
  localparam int SEL_W = 3;
  localparam int TSEL_LSB = 0;
  localparam int OSEL_LSB = 4;
  localparam int LATCH_BIT = 3;
  localparam int NUM_FLAGS = 8;
  localparam int NUM_BASE_FLAGS = 6;
  localparam logic [7:0] SELECT_RW_MASK = 8'h77;
  localparam logic [7:0] CONTROL_RW_MASK = 8'h08;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // flag bit positions
  localparam int FLAG_PER = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_OVF_PER = 3;
  localparam int FLAG_OVF_CMP_A = 4;
  localparam int FLAG_OVF_CMP_B = 5;
  localparam int FLAG_JOINT_A = 6;
  localparam int FLAG_JOINT_B = 7;

  // window target select codes
  typedef enum logic [2:0] {
    TMA_SEL_COUNT = 3'b000,
    TMA_SEL_CAPTURE = 3'b001,
    TMA_SEL_PERIOD = 3'b010,
    TMA_SEL_CMP_A = 3'b011,
    TMA_SEL_CMP_B = 3'b100
  } tma_sel_t;

endpackage

// ===== rtl/tma_access.sv
// byte-window access, read latching and interrupt flags of a timer
// assumes counter core supplies live values, captures and wrap pulses
module tma_access #(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] upcount_value,
  input wire logic [15:0] upcount_capture,
  input wire logic [23:0] wrap_count_value,
  input wire logic [23:0] wrap_count_capture,
  input wire logic period_wrap_evt,
  input wire logic wrap_period_evt,
  output logic upcount_load,
  output logic [15:0] upcount_load_value,
  output logic wrap_load,
  output logic [23:0] wrap_load_value,
  output logic [15:0] upcount_period,
  output logic [15:0] upcount_compare_a,
  output logic [15:0] upcount_compare_b,
  output logic [23:0] wrap_count_period,
  output logic [23:0] wrap_count_compare_a,
  output logic [23:0] wrap_count_compare_b,
  output logic latch_mode,
  output logic timer_irq
);

  // ***********************************************
  // declarations
  // ***********************************************
  logic [7:0] select_reg;
  logic [7:0] timer_irq_mask;
  logic [7:0] timer_irq_flags;
  logic [15:0] tim_hold;
  logic [23:0] ovf_hold;
  logic [15:0] prev_tim;
  logic [23:0] prev_ovf;
  tma_pkg::tma_sel_t tsel;
  tma_pkg::tma_sel_t osel;
  logic rd_tim_lo;
  logic rd_ovf_lo;
  logic wr_tim;
  logic wr_ovf;
  logic tim_lane;
  logic [1:0] ovf_lane;
  logic tim_lo_count_rd;
  logic ovf_latch_now;
  logic [15:0] tim_word;
  logic [23:0] ovf_word;
  logic [7:0] next_rdata;
  logic [7:0] set_pulse;
  logic [7:0] mask_rw;
  logic tim_moved;
  logic ovf_moved;
  logic hit_a;
  logic hit_b;
  logic ovf_hit_a;
  logic ovf_hit_b;

  // ***********************************************
  // decode
  // ***********************************************
  // reserved select codes fall to the default branches below
  assign tsel = tma_pkg::tma_sel_t'(select_reg[tma_pkg::TSEL_LSB +: tma_pkg::SEL_W]);
  assign osel = tma_pkg::tma_sel_t'(select_reg[tma_pkg::OSEL_LSB +: tma_pkg::SEL_W]);
  assign rd_tim_lo = sfr_rd && (sfr_addr == tma_pkg::ADDR_TIM_LO);
  assign rd_ovf_lo = sfr_rd && (sfr_addr == tma_pkg::ADDR_OVF_LO);
  assign wr_tim = sfr_wr && (sfr_addr == tma_pkg::ADDR_TIM_LO
                             || sfr_addr == tma_pkg::ADDR_TIM_HI);
  assign wr_ovf = sfr_wr && (sfr_addr == tma_pkg::ADDR_OVF_LO
                             || sfr_addr == tma_pkg::ADDR_OVF_MID
                             || sfr_addr == tma_pkg::ADDR_OVF_TOP);
  assign tim_lane = (sfr_addr == tma_pkg::ADDR_TIM_HI);
  assign ovf_lane = sfr_addr[1:0] - tma_pkg::ADDR_OVF_LO[1:0];
  // joint mask bits only exist in the extended variant
  assign mask_rw = EXTENDED ? 8'hFF : 8'h3F;

  // ***********************************************
  // read latching
  // ***********************************************
  // timer latch trigger
  assign tim_lo_count_rd = rd_tim_lo && (tsel == tma_pkg::TMA_SEL_COUNT);
  assign ovf_latch_now = (osel == tma_pkg::TMA_SEL_COUNT)
                         && ((rd_ovf_lo && !latch_mode) || (rd_tim_lo && latch_mode));

  // holding latch for the timer count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tim_hold <= 16'h0000;
    end else if (tim_lo_count_rd) begin
      tim_hold <= upcount_value;
    end
  end

  // holding latch for the overflow count, all three bytes at once
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovf_hold <= 24'h00_0000;
    end else if (ovf_latch_now) begin
      ovf_hold <= wrap_count_value;
    end
  end

  // ***********************************************
  // read path
  // ***********************************************
  // timer target mux
  // count target shows the held high byte
  always_comb begin
    case (tsel)
      tma_pkg::TMA_SEL_COUNT: tim_word = {tim_hold[15:8], upcount_value[7:0]};
      tma_pkg::TMA_SEL_CAPTURE: tim_word = upcount_capture;
      tma_pkg::TMA_SEL_PERIOD: tim_word = upcount_period;
      tma_pkg::TMA_SEL_CMP_A: tim_word = upcount_compare_a;
      tma_pkg::TMA_SEL_CMP_B: tim_word = upcount_compare_b;
      default: tim_word = 16'h0000;
    endcase
  end

  // upper bytes of the count target come from the hold
  always_comb begin
    case (osel)
      tma_pkg::TMA_SEL_COUNT: begin
        // latch mode 1 already captured the low byte with the timer
        ovf_word = {ovf_hold[23:8], latch_mode ? ovf_hold[7:0] : wrap_count_value[7:0]};
      end
      tma_pkg::TMA_SEL_CAPTURE: ovf_word = wrap_count_capture;
      tma_pkg::TMA_SEL_PERIOD: ovf_word = wrap_count_period;
      tma_pkg::TMA_SEL_CMP_A: ovf_word = wrap_count_compare_a;
      tma_pkg::TMA_SEL_CMP_B: ovf_word = wrap_count_compare_b;
      default: ovf_word = 24'h00_0000;
    endcase
  end

  // byte port read mux; unmapped offsets read zero
  // every timer and overflow window
  always_comb begin
    case (sfr_addr)
      tma_pkg::ADDR_FLAGS: next_rdata = timer_irq_flags;
      tma_pkg::ADDR_TIM_LO: next_rdata = tim_word[7:0];
      tma_pkg::ADDR_TIM_HI: next_rdata = tim_word[15:8];
      tma_pkg::ADDR_OVF_LO: next_rdata = ovf_word[7:0];
      tma_pkg::ADDR_OVF_MID: next_rdata = ovf_word[15:8];
      tma_pkg::ADDR_OVF_TOP: next_rdata = ovf_word[23:16];
      tma_pkg::ADDR_MASK: next_rdata = timer_irq_mask;
      tma_pkg::ADDR_SELECT: next_rdata = select_reg;
      tma_pkg::ADDR_CONTROL: next_rdata = {4'h0, latch_mode, 3'b000};
      default: next_rdata = tma_pkg::BYTE_RESET;
    endcase
  end

  // read data stands until the next read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata <= tma_pkg::BYTE_RESET;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ***********************************************
  // direct registers
  // ***********************************************
  // select, control and mask; reserved bits never store
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      select_reg <= tma_pkg::BYTE_RESET;
      latch_mode <= 1'b0;
      timer_irq_mask <= tma_pkg::BYTE_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == tma_pkg::ADDR_SELECT) begin
        select_reg <= sfr_wdata & tma_pkg::SELECT_RW_MASK;
      end
      if (sfr_addr == tma_pkg::ADDR_CONTROL) begin
        latch_mode <= sfr_wdata[tma_pkg::LATCH_BIT];
      end
      if (sfr_addr == tma_pkg::ADDR_MASK) begin
        timer_irq_mask <= sfr_wdata & mask_rw;
      end
    end
  end

  // ***********************************************
  // window writes
  // ***********************************************
  // timer side: one byte lane replaced; captures are read only
  // high window writes bits 15:8
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      upcount_period <= 16'h0000;
      upcount_compare_a <= 16'h0000;
      upcount_compare_b <= 16'h0000;
      upcount_load <= 1'b0;
      upcount_load_value <= 16'h0000;
    end else begin
      upcount_load <= 1'b0;
      if (wr_tim) begin
        case (tsel)
          tma_pkg::TMA_SEL_COUNT: begin
            // counter lives in the core; send it a one-cycle load
            upcount_load <= 1'b1;
            upcount_load_value <= upcount_value;
            upcount_load_value[tim_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_PERIOD: begin
            upcount_period[tim_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_CMP_A: begin
            upcount_compare_a[tim_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_CMP_B: begin
            upcount_compare_b[tim_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // overflow side: lanes 0..2 map bits 7:0, 15:8, 23:16
  // lane 0..2 write, chosen by ovf_lane
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrap_count_period <= 24'h00_0000;
      wrap_count_compare_a <= 24'h00_0000;
      wrap_count_compare_b <= 24'h00_0000;
      wrap_load <= 1'b0;
      wrap_load_value <= 24'h00_0000;
    end else begin
      wrap_load <= 1'b0;
      if (wr_ovf) begin
        case (osel)
          tma_pkg::TMA_SEL_COUNT: begin
            wrap_load <= 1'b1;
            wrap_load_value <= wrap_count_value;
            wrap_load_value[ovf_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_PERIOD: begin
            wrap_count_period[ovf_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_CMP_A: begin
            wrap_count_compare_a[ovf_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          tma_pkg::TMA_SEL_CMP_B: begin
            wrap_count_compare_b[ovf_lane*tma_pkg::BYTE_W +: tma_pkg::BYTE_W] <= sfr_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ***********************************************
  // event detection
  // ***********************************************
  // a compare fires only when the count arrives, not while it sits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_tim <= 16'h0000;
      prev_ovf <= 24'h00_0000;
    end else begin
      prev_tim <= upcount_value;
      prev_ovf <= wrap_count_value;
    end
  end

  assign tim_moved = (upcount_value != prev_tim);
  assign ovf_moved = (wrap_count_value != prev_ovf);
  assign hit_a = tim_moved && (upcount_value == upcount_compare_a);
  assign hit_b = tim_moved && (upcount_value == upcount_compare_b);
  assign ovf_hit_a = ovf_moved && (wrap_count_value == wrap_count_compare_a);
  assign ovf_hit_b = ovf_moved && (wrap_count_value == wrap_count_compare_b);

  always_comb begin
    set_pulse = 8'h00;
    set_pulse[tma_pkg::FLAG_PER] = period_wrap_evt;
    set_pulse[tma_pkg::FLAG_CMP_A] = hit_a;
    set_pulse[tma_pkg::FLAG_CMP_B] = hit_b;
    set_pulse[tma_pkg::FLAG_OVF_PER] = wrap_period_evt;
    set_pulse[tma_pkg::FLAG_OVF_CMP_A] = ovf_hit_a;
    set_pulse[tma_pkg::FLAG_OVF_CMP_B] = ovf_hit_b;
    set_pulse[tma_pkg::FLAG_JOINT_A] = EXTENDED && hit_a
                                       && (wrap_count_value == wrap_count_compare_a);
    set_pulse[tma_pkg::FLAG_JOINT_B] = EXTENDED && hit_b
                                       && (wrap_count_value == wrap_count_compare_b);
  end

  // ***********************************************
  // flags and interrupt
  // ***********************************************
  // sticky flags, write zero to clear
  tma_flag_bank #(
    .WIDTH(tma_pkg::NUM_FLAGS)
  ) u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .set_pulse(set_pulse),
    .clear_wr(sfr_wr && (sfr_addr == tma_pkg::ADDR_FLAGS)),
    .wdata(sfr_wdata),
    .flags(timer_irq_flags)
  );

  // registered request, one cycle behind the flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(timer_irq_flags & timer_irq_mask);
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_lo_count_read;
    rd_tim_lo && (tsel == tma_pkg::TMA_SEL_COUNT);
  endsequence

  sequence s_hi_count_read;
    sfr_rd && (sfr_addr == tma_pkg::ADDR_TIM_HI) && (tsel == tma_pkg::TMA_SEL_COUNT);
  endsequence

  a_tim_latch: assert property (s_lo_count_read |=> tim_hold == $past(upcount_value))
    else $error("timer count not latched on low read");
  // a quiet cycle between the two reads keeps the hold from being reloaded
  a_hi_from_hold: assert property (
    s_lo_count_read ##1 !sfr_rd ##1 s_hi_count_read
    |=> sfr_rdata == $past(upcount_value, 3) >> tma_pkg::BYTE_W)
    else $error("high read did not return latched byte");
  a_hi_period_read: assert property (
    sfr_rd && sfr_addr == tma_pkg::ADDR_TIM_HI && tsel == tma_pkg::TMA_SEL_PERIOD
    |=> sfr_rdata == $past(upcount_period[15:8]))
    else $error("high window period byte wrong");
  a_ovf_mode0: assert property (
    rd_ovf_lo && !latch_mode && osel == tma_pkg::TMA_SEL_COUNT
    |=> ovf_hold == $past(wrap_count_value))
    else $error("overflow count not latched in mode 0");
  a_ovf_mode1: assert property (
    rd_tim_lo && latch_mode && osel == tma_pkg::TMA_SEL_COUNT
    |=> ovf_hold == $past(wrap_count_value))
    else $error("overflow count not latched with timer");
  a_ovf_mid_read: assert property (
    sfr_rd && sfr_addr == tma_pkg::ADDR_OVF_MID && osel == tma_pkg::TMA_SEL_COUNT
    |=> sfr_rdata == $past(ovf_hold[15:8]))
    else $error("overflow mid byte not from latch");
  a_ovf_top_read: assert property (
    sfr_rd && sfr_addr == tma_pkg::ADDR_OVF_TOP && osel == tma_pkg::TMA_SEL_COUNT
    |=> sfr_rdata == $past(ovf_hold[23:16]))
    else $error("overflow top byte not from latch");
  a_per_flag_set: assert property (period_wrap_evt |=> timer_irq_flags[tma_pkg::FLAG_PER])
    else $error("period wrap flag not set");
  a_cmp_flag_set: assert property (hit_a |=> timer_irq_flags[tma_pkg::FLAG_CMP_A])
    else $error("compare flag not set");
  a_flag_sticky: assert property (
    !(sfr_wr && sfr_addr == tma_pkg::ADDR_FLAGS)
    |=> (timer_irq_flags & $past(timer_irq_flags)) == $past(timer_irq_flags))
    else $error("flag dropped without a clear");
  a_irq_request: assert property (
    (|(timer_irq_flags & timer_irq_mask)) |=> timer_irq)
    else $error("interrupt missing for enabled flag");
  a_irq_quiet: assert property (
    !(|(timer_irq_flags & timer_irq_mask)) |=> !timer_irq)
    else $error("interrupt raised with no enabled flag");

endmodule

// ===== rtl/tma_flag_bank.sv
// sticky event flags, cleared by writing zero
// assumes set pulses and the write strobe come from the same clock
module tma_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic clear_wr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] flags
);

  // ***********************************************
  // one sticky bit per event
  // ***********************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // set wins over a same-cycle zero write so no event is lost
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        flags[i] <= 1'b0;
      end else if (set_pulse[i]) begin
        flags[i] <= 1'b1;
      end else if (clear_wr && !wdata[i]) begin
        flags[i] <= 1'b0;
      end
    end
  end

endmodule
